// ==== src/cmb_top.sv ====
// CAN receive queue, transmit buffers and acceptance filter
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module cmb_top
    import cmb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Receive side of the protocol engine
    input wire logic rx_we,
    input wire logic [3:0] rx_idx,
    input wire logic [7:0] rx_data,
    input wire logic rx_eof,
    input wire logic rx_own,
    // Transmit side of the protocol engine
    input wire logic arb_start,
    input wire logic tx_on_bus,
    input wire logic tx_done,
    input wire logic [3:0] tx_rd_idx,
    output logic [1:0] tx_sel,
    output logic tx_sel_valid,
    output logic [7:0] tx_rd_data,
    // Interrupt requests
    output logic rx_irq,
    output logic ovr_irq,
    output logic tx_irq
);
    logic [7:0] fg_reg [NBYTE];
    logic [7:0] bg_reg [NBYTE];
    logic [7:0] txb_reg [NTX][NBYTE];
    logic [7:0] local_priority_field_reg [NTX];
    logic [7:0] acc_reg [NFLT];
    logic [7:0] msk_reg [NFLT];
    logic rx_full_reg, ovr_reg, bg_pend_reg, loop_reg;
    logic [2:0] hit_reg, pend_hit_reg;
    logic [1:0] rie_reg;
    logic [2:0] txe_reg, tie_reg, abrq_reg, abak_reg;
    cmb_fmode_t mode_reg;
    logic [1:0] sel_reg;
    logic selv_reg;
    logic [7:0] rdata_reg, tx_rd_data_reg, rd_val;
    logic rx_irq_reg, ovr_irq_reg, tx_irq_reg;
    logic accept, copy_new, copy_pend, clr_full, clr_ovr;
    logic [2:0] clr_txe, done_vec, ab_grant;

    cmb_filt_if fi ();
    cmb_sel_if si ();

    cmb_filter u_filter (
        .f(fi.filt)
    );

    cmb_tx_sched u_sched (
        .s(si.sched)
    );

    function automatic logic is_tx(input logic [6:0] a);
        is_tx = (a >= A_TX0) && (a < A_RFLG);
    endfunction

    function automatic logic [1:0] tx_slot(input logic [6:0] a);
        tx_slot = 2'(a[5:4] - 2'h1);
    endfunction

    // Filter operands, first register on the top identifier bits
    always_comb begin
        fi.id = {bg_reg[0], bg_reg[1], bg_reg[2], bg_reg[3]};
        for (int i = 0; i < NFLT; i++) begin
            fi.acc[63-8*i -: 8] = acc_reg[i];
            fi.msk[63-8*i -: 8] = msk_reg[i];
        end
        fi.mode = mode_reg;
    end

    always_comb begin
        for (int i = 0; i < NTX; i++) begin
            si.local_priority_field[8*i +: 8] = local_priority_field_reg[i];
        end
        si.ready = ~txe_reg;
    end

    // Receive events
    assign accept = rx_eof && fi.hit && (!rx_own || loop_reg);
    assign copy_new = accept && !rx_full_reg;
    assign copy_pend = bg_pend_reg && (!rx_full_reg || clr_full);
    assign clr_full = wr && addr == A_RFLG && wdata[RF_FULL];
    assign clr_ovr = wr && addr == A_RFLG && wdata[RF_OVR];

    // Transmit events
    assign clr_txe = (wr && addr == A_TFLG) ? wdata[2:0] : 3'h0;
    assign done_vec = (tx_done && selv_reg) ? 3'(1 << sel_reg) : 3'h0;

    always_comb begin
        for (int i = 0; i < NTX; i++) begin
            ab_grant[i] = abrq_reg[i] && !txe_reg[i] && !done_vec[i] &&
                !(tx_on_bus && selv_reg && sel_reg == 2'(i));
        end
    end

    // Background buffer, locked only while it holds a pending frame
    always_ff @(posedge clk) begin
        if (rx_we && !bg_pend_reg && rx_idx < BYTE_LIM) begin
            bg_reg[rx_idx] <= rx_data;
        end
    end

    // Foreground buffer
    always_ff @(posedge clk) begin
        if (copy_new || copy_pend) begin
            for (int i = 0; i < NBYTE; i++) begin
                fg_reg[i] <= bg_reg[i];
            end
        end
    end

    // Receive flags and hit indicator
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_full_reg <= 1'b0;
            bg_pend_reg <= 1'b0;
            ovr_reg <= 1'b0;
            hit_reg <= 3'h0;
            pend_hit_reg <= 3'h0;
        end else begin
            if (copy_new || copy_pend) begin
                rx_full_reg <= 1'b1;
            end else if (clr_full) begin
                rx_full_reg <= 1'b0;
            end
            if (accept && rx_full_reg && !bg_pend_reg) begin
                bg_pend_reg <= 1'b1;
                pend_hit_reg <= fi.idx;
            end else if (copy_pend) begin
                bg_pend_reg <= 1'b0;
            end
            if (copy_new) begin
                hit_reg <= fi.idx;
            end else if (copy_pend) begin
                hit_reg <= pend_hit_reg;
            end
            if (accept && bg_pend_reg) begin
                ovr_reg <= 1'b1;
            end else if (clr_ovr) begin
                ovr_reg <= 1'b0;
            end
        end
    end

    // Configuration and filter registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rie_reg <= 2'h0;
            tie_reg <= 3'h0;
            mode_reg <= FM_32;
            loop_reg <= 1'b0;
            for (int i = 0; i < NFLT; i++) begin
                acc_reg[i] <= ACC_RST;
                msk_reg[i] <= MSK_RST;
            end
        end else if (wr) begin
            case (addr)
                A_RIE: rie_reg <= wdata[1:0];
                A_TIE: tie_reg <= wdata[2:0];
                A_IDAC: mode_reg <= cmb_fmode_t'(wdata[1:0]);
                A_MCR: loop_reg <= wdata[MCR_LOOP];
                default: begin
                    if (addr[6:3] == A_ACC[6:3]) begin
                        acc_reg[addr[2:0]] <= wdata;
                    end else if (addr[6:3] == A_MSK[6:3]) begin
                        msk_reg[addr[2:0]] <= wdata;
                    end
                end
            endcase
        end
    end

    // Transmit buffers and priorities
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NTX; i++) begin
                local_priority_field_reg[i] <= LOCAL_PRIORITY_FIELD_RST;
            end
        end else if (wr && is_tx(addr)) begin
            if (addr[3:0] < BYTE_LIM) begin
                txb_reg[tx_slot(addr)][addr[3:0]] <= wdata;
            end else if (addr[3:0] == LOCAL_PRIORITY_FIELD_OFS) begin
                local_priority_field_reg[tx_slot(addr)] <= wdata;
            end
        end
    end

    // Transmit flags, set wins over clear for txe_reg and abak_reg, clear wins for abrq_reg
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            txe_reg <= TXE_RST;
            abrq_reg <= 3'h0;
            abak_reg <= 3'h0;
        end else begin
            txe_reg <= (txe_reg & ~clr_txe) | done_vec | ab_grant;
            abak_reg <= (abak_reg & ~clr_txe & ~done_vec) | ab_grant;
            if (wr && addr == A_TCTL) begin
                abrq_reg <= wdata[2:0] & ~done_vec & ~ab_grant;
            end else begin
                abrq_reg <= abrq_reg & ~done_vec & ~ab_grant;
            end
        end
    end

    // Buffer selection at each arbitration
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sel_reg <= 2'h0;
            selv_reg <= 1'b0;
        end else if (arb_start) begin
            sel_reg <= si.pick;
            selv_reg <= si.found;
        end else if (done_vec != 3'h0 || ab_grant[sel_reg]) begin
            selv_reg <= 1'b0;
        end
    end

    // Register read mux
    always_comb begin
        rd_val = 8'h00;
        if (addr < A_TX0) begin
            if (addr[3:0] < BYTE_LIM) begin
                rd_val = fg_reg[addr[3:0]];
            end
        end else if (is_tx(addr)) begin
            if (addr[3:0] < BYTE_LIM) begin
                rd_val = txb_reg[tx_slot(addr)][addr[3:0]];
            end else if (addr[3:0] == LOCAL_PRIORITY_FIELD_OFS) begin
                rd_val = local_priority_field_reg[tx_slot(addr)];
            end
        end else begin
            case (addr)
                A_RFLG: rd_val = {6'h00, ovr_reg, rx_full_reg};
                A_RIE: rd_val = {6'h00, rie_reg};
                A_TFLG: rd_val = {5'h00, txe_reg};
                A_TCTL: rd_val = {1'b0, abak_reg, 1'b0, abrq_reg};
                A_TIE: rd_val = {5'h00, tie_reg};
                A_IDAC: rd_val = {1'b0, hit_reg, 2'h0, mode_reg};
                A_MCR: rd_val = {7'h00, loop_reg};
                default: begin
                    if (addr[6:3] == A_ACC[6:3]) begin
                        rd_val = acc_reg[addr[2:0]];
                    end else if (addr[6:3] == A_MSK[6:3]) begin
                        rd_val = msk_reg[addr[2:0]];
                    end
                end
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_reg <= 8'h00;
            tx_rd_data_reg <= 8'h00;
            rx_irq_reg <= 1'b0;
            ovr_irq_reg <= 1'b0;
            tx_irq_reg <= 1'b0;
        end else begin
            rdata_reg <= rd ? rd_val : 8'h00;
            if (tx_rd_idx < BYTE_LIM) begin
                tx_rd_data_reg <= txb_reg[sel_reg][tx_rd_idx];
            end else begin
                tx_rd_data_reg <= 8'h00;
            end
            rx_irq_reg <= rx_full_reg && rie_reg[0];
            ovr_irq_reg <= ovr_reg && rie_reg[1];
            tx_irq_reg <= |(txe_reg & tie_reg);
        end
    end

    assign rdata = rdata_reg;
    assign tx_rd_data = tx_rd_data_reg;
    assign tx_sel = sel_reg;
    assign tx_sel_valid = selv_reg;
    assign rx_irq = rx_irq_reg;
    assign ovr_irq = ovr_irq_reg;
    assign tx_irq = tx_irq_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_free_accept;
        accept && !rx_full_reg;
    endsequence
    sequence s_refill;
        rx_full_reg && bg_pend_reg && clr_full;
    endsequence

    rx_copy_a: assert property (s_free_accept |=> rx_full_reg
        && hit_reg == $past(fi.idx))
        else $error("accepted frame not copied");
    rx_irq_a: assert property ((s_free_accept and rie_reg[0])
        ##1 rie_reg[0] |=> rx_irq)
        else $error("receive interrupt late");
    closed_mode_a: assert property (mode_reg == FM_CLOSED
        && !rx_full_reg && !bg_pend_reg |=> !rx_full_reg)
        else $error("closed filter set receive-full");
    own_frame_a: assert property (rx_eof && rx_own && !loop_reg
        && !rx_full_reg && !bg_pend_reg |=> !rx_full_reg)
        else $error("own frame reached foreground");
    overrun_a: assert property (accept && bg_pend_reg
        |=> ovr_reg && bg_pend_reg)
        else $error("overrun not flagged");
    refill_a: assert property (s_refill |=> rx_full_reg
        && !bg_pend_reg)
        else $error("pending frame not refilled");
    flag_clear_a: assert property (clr_full && !bg_pend_reg
        && !accept |=> !rx_full_reg)
        else $error("receive-full not cleared");
    tx_done_a: assert property (tx_done && selv_reg
        |=> txe_reg[$past(sel_reg)] && !abak_reg[$past(sel_reg)])
        else $error("sent buffer not released");
    abort_a: assert property (abrq_reg[0] && !txe_reg[0]
        && !tx_on_bus && !done_vec[0] |=> txe_reg[0] && abak_reg[0])
        else $error("abort not acknowledged");
    local_priority_field_pick_a: assert property (arb_start && txe_reg == 3'h0
        && local_priority_field_reg[1] < local_priority_field_reg[0] && local_priority_field_reg[1] < local_priority_field_reg[2]
        |=> selv_reg && sel_reg == 2'h1)
        else $error("wrong buffer selected");
endmodule // cmb_top

// ==== src/cmb_pkg.sv ====
// Shared constants, types and helpers of the CAN message buffer block
package cmb_pkg;
    localparam int NBYTE = 13;
    localparam int NTX = 3;
    localparam int NFLT = 8;
    localparam logic [3:0] BYTE_LIM = 4'hD;
    localparam logic [3:0] LOCAL_PRIORITY_FIELD_OFS = BYTE_LIM;
    localparam logic [6:0] A_TX0 = 7'h10;
    localparam logic [6:0] A_RFLG = 7'h40;
    localparam logic [6:0] A_RIE = 7'h41;
    localparam logic [6:0] A_TFLG = 7'h42;
    localparam logic [6:0] A_TCTL = 7'h43;
    localparam logic [6:0] A_TIE = 7'h44;
    localparam logic [6:0] A_IDAC = 7'h45;
    localparam logic [6:0] A_MCR = 7'h46;
    localparam logic [6:0] A_ACC = 7'h48;
    localparam logic [6:0] A_MSK = 7'h50;
    localparam int RF_FULL = 0;
    localparam int RF_OVR = 1;
    localparam int MCR_LOOP = 0;
    localparam int IDE_POS = 19;
    localparam logic [2:0] TXE_RST = 3'h7;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] MSK_RST = 8'h00;
    localparam logic [7:0] LOCAL_PRIORITY_FIELD_RST = 8'h00;
    localparam logic [15:0] M16_STD = 16'hFFF0;
    localparam logic [15:0] M16_EXT = 16'hFFE7;

    typedef enum logic [1:0] {
        FM_32,
        FM_16,
        FM_8,
        FM_CLOSED
    } cmb_fmode_t;

    // Set mask bits make the identifier bit a don't-care
    function automatic logic id_match(input logic [31:0] id,
                                      input logic [31:0] acc,
                                      input logic [31:0] msk);
        id_match = &(~(id ^ acc) | msk);
    endfunction
endpackage

// ==== src/cmb_if.sv ====
// Interfaces between the buffer top and its filter and scheduler
`timescale 1ns/1ps
interface cmb_filt_if;
    import cmb_pkg::*;
    logic [31:0] id;
    logic [63:0] acc;
    logic [63:0] msk;
    cmb_fmode_t mode;
    logic hit;
    logic [2:0] idx;
    modport top(output id, acc, msk, mode, input hit, idx);
    modport filt(input id, acc, msk, mode, output hit, idx);
endinterface

interface cmb_sel_if;
    logic [2:0] ready;
    logic [23:0] local_priority_field;
    logic found;
    logic [1:0] pick;
    modport top(output ready, local_priority_field, input found, pick);
    modport sched(input ready, local_priority_field, output found, pick);
endinterface

// ==== src/cmb_filter.sv ====
// Identifier acceptance filter, four modes
`timescale 1ns/1ps
module cmb_filter
    import cmb_pkg::*;
(
    // Filter operands and result
    cmb_filt_if.filt f
);
    logic [7:0] h;
    logic [15:0] m16;

    always_comb begin
        h = 8'h00;
        m16 = f.id[IDE_POS] ? M16_EXT : M16_STD;
        case (f.mode)
            FM_32: begin
                for (int k = 0; k < 2; k++) begin
                    h[k] = id_match(f.id, f.acc[63-32*k -: 32],
                                    f.msk[63-32*k -: 32]);
                end
            end
            FM_16: begin
                for (int k = 0; k < 4; k++) begin
                    h[k] = id_match({16'h0000, f.id[31:16]},
                                    {16'h0000, f.acc[63-16*k -: 16]},
                                    {16'hFFFF, f.msk[63-16*k -: 16] | ~m16});
                end
            end
            FM_8: begin
                for (int k = 0; k < 8; k++) begin
                    h[k] = id_match({24'h00_0000, f.id[31:24]},
                                    {24'h00_0000, f.acc[63-8*k -: 8]},
                                    {24'hFF_FFFF, f.msk[63-8*k -: 8]});
                end
            end
            default: h = 8'h00;
        endcase
        f.hit = |h;
        f.idx = 3'h0;
        for (int k = 7; k >= 0; k--) begin
            if (h[k]) begin
                f.idx = 3'(k);
            end
        end
    end
endmodule // cmb_filter

// ==== src/cmb_tx_sched.sv ====
// Picks the ready transmit buffer with the lowest local priority value
`timescale 1ns/1ps
module cmb_tx_sched (
    // Ready set and priorities
    cmb_sel_if.sched s
);
    logic [7:0] best;

    always_comb begin
        s.found = 1'b0;
        s.pick = 2'h0;
        best = 8'hFF;
        for (int i = 0; i < 3; i++) begin
            if (s.ready[i] && (!s.found || s.local_priority_field[8*i +: 8] < best)) begin
                s.found = 1'b1;
                s.pick = 2'(i);
                best = s.local_priority_field[8*i +: 8];
            end
        end
    end
endmodule // cmb_tx_sched

// ==== testbench/cmb_engine_model.sv ====
// Protocol engine model feeding the buffer block's receive and transmit links
`timescale 1ns/1ps
module cmb_engine_model (
    // Clock
    input wire logic clk,
    // Receive link
    output logic rx_we,
    output logic [3:0] rx_idx,
    output logic [7:0] rx_data,
    output logic rx_eof,
    output logic rx_own,
    // Transmit link
    output logic arb_start,
    output logic tx_on_bus,
    output logic tx_done,
    output logic [3:0] tx_rd_idx,
    input wire logic [7:0] tx_rd_data
);
    initial begin
        rx_we = 1'b0;
        rx_idx = 4'h0;
        rx_data = 8'h00;
        rx_eof = 1'b0;
        rx_own = 1'b0;
        arb_start = 1'b0;
        tx_on_bus = 1'b0;
        tx_done = 1'b0;
        tx_rd_idx = 4'h0;
    end

    // Standard frame, zero identifier, payload counting up from base
    task automatic send_frame(input logic [7:0] base, input logic own);
        for (int i = 0; i < 13; i++) begin
            @(posedge clk);
            rx_we <= 1'b1;
            rx_idx <= 4'(i);
            rx_data <= (i < 4) ? 8'h00 : base + 8'(i - 4);
        end
        @(posedge clk);
        rx_we <= 1'b0;
        rx_data <= ~rx_data;
        @(posedge clk);
        rx_eof <= 1'b1;
        rx_own <= own;
        @(posedge clk);
        rx_eof <= 1'b0;
        rx_own <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Start of arbitration; selection is settled afterwards
    task automatic arbitrate();
        @(posedge clk);
        arb_start <= 1'b1;
        @(posedge clk);
        arb_start <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic set_bus(input logic v);
        @(posedge clk);
        tx_on_bus <= v;
    endtask

    task automatic fetch(input logic [3:0] idx, output logic [7:0] d);
        @(posedge clk);
        tx_rd_idx <= idx;
        @(posedge clk);
        @(negedge clk);
        d = tx_rd_data;
    endtask

    task automatic finish_tx();
        @(posedge clk);
        tx_done <= 1'b1;
        tx_on_bus <= 1'b0;
        @(posedge clk);
        tx_done <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
endmodule // cmb_engine_model

// ==== testbench/cmb_top_tb.sv ====
// Self-checking bench for the CAN message buffer block
`timescale 1ns/1ps
module cmb_top_tb
    import cmb_pkg::*;
;
    logic clk;
    logic reset_n;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic rx_we, rx_eof, rx_own, arb_start, tx_on_bus, tx_done;
    logic [3:0] rx_idx;
    logic [3:0] tx_rd_idx;
    logic [7:0] rx_data;
    logic [7:0] tx_rd_data;
    logic [1:0] tx_sel;
    logic tx_sel_valid, rx_irq, ovr_irq, tx_irq;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [7:0] d;
    logic [1:0] md [6] = '{2'd0, 2'd1, 2'd2, 2'd0, 2'd0, 2'd3};
    int na [6] = '{4, 2, 2, 8, 8, 0};
    int nm [6] = '{0, 0, 0, 0, 4, 0};
    logic ef [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [2:0] eh [6] = '{3'd1, 3'd1, 3'd2, 3'd0, 3'd0, 3'd0};
    logic [7:0] pr [3] = '{8'h05, 8'h03, 8'h09};

    cmb_top i_dut (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_we(rx_we),
        .rx_idx(rx_idx), .rx_data(rx_data), .rx_eof(rx_eof),
        .rx_own(rx_own), .arb_start(arb_start), .tx_on_bus(tx_on_bus),
        .tx_done(tx_done), .tx_rd_idx(tx_rd_idx), .tx_sel(tx_sel),
        .tx_sel_valid(tx_sel_valid), .tx_rd_data(tx_rd_data),
        .rx_irq(rx_irq), .ovr_irq(ovr_irq), .tx_irq(tx_irq));

    cmb_engine_model i_eng (.clk(clk), .rx_we(rx_we), .rx_idx(rx_idx),
        .rx_data(rx_data), .rx_eof(rx_eof), .rx_own(rx_own),
        .arb_start(arb_start), .tx_on_bus(tx_on_bus), .tx_done(tx_done),
        .tx_rd_idx(tx_rd_idx), .tx_rd_data(tx_rd_data));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic summarize();
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm_s, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm_s, e, g);
            bad_count++;
        end
    endtask

    task automatic wr_reg(input logic [6:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rchk(input string nm_s, input logic [6:0] a,
                        input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(nm_s, e, rdata & m);
    endtask

    // Filter mode, then acceptance and mask bytes set to all ones up to n
    task automatic cfg(input logic [1:0] m, input int nacc, input int nmsk);
        wr_reg(A_IDAC, {6'h00, m});
        for (int j = 0; j < 8; j++) begin
            wr_reg(A_ACC + 7'(j), (j < nacc) ? 8'hFF : 8'h00);
            wr_reg(A_MSK + 7'(j), (j < nmsk) ? 8'hFF : 8'h00);
        end
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        reset_n <= 1'b0;
        addr <= 7'h00;
        wdata <= 8'h00;
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rchk("tflag", A_TFLG, 8'hFF, {5'h00, TXE_RST});
        rchk("idac", A_IDAC, 8'h73, 8'h00);
        rchk("rflag", A_RFLG, 8'h03, 8'h00);
        rchk("unmapped", 7'h7F, 8'hFF, 8'h00);
        wr_reg(A_RIE, 8'h03);
        wr_reg(A_TIE, 8'h07);
        // Filter modes, bank hits, mask don't-care and closed mode
        for (int k = 0; k < 6; k++) begin
            cfg(md[k], na[k], nm[k]);
            i_eng.send_frame(8'h40, 1'b0);
            rchk("rflag", A_RFLG, 8'h03, {7'h00, ef[k]});
            if (ef[k]) begin
                chk("rx_irq", 8'h01, {7'h00, rx_irq});
                rchk("hit", A_IDAC, 8'h73, {1'b0, eh[k], 2'b00, md[k]});
                wr_reg(A_RFLG, 8'h01);
            end
        end
        // Own frames, plain and in loop-back
        cfg(2'd0, 0, 0);
        i_eng.send_frame(8'h50, 1'b1);
        rchk("rflag", A_RFLG, 8'h03, 8'h00);
        wr_reg(A_MCR, 8'h01);
        i_eng.send_frame(8'h50, 1'b1);
        rchk("rflag", A_RFLG, 8'h03, 8'h01);
        wr_reg(A_RFLG, 8'h01);
        wr_reg(A_MCR, 8'h00);
        // Queue fills, third frame overruns, pending frame refills
        i_eng.send_frame(8'h10, 1'b0);
        i_eng.send_frame(8'h20, 1'b0);
        i_eng.send_frame(8'h30, 1'b0);
        rchk("rflag", A_RFLG, 8'h03, 8'h03);
        chk("ovr_irq", 8'h01, {7'h00, ovr_irq});
        rchk("fg byte4", 7'h04, 8'hFF, 8'h10);
        wr_reg(A_RFLG, 8'h03);
        rchk("rflag", A_RFLG, 8'h03, 8'h01);
        rchk("fg byte4", 7'h04, 8'hFF, 8'h20);
        rchk("fg byte12", 7'h0C, 8'hFF, 8'h28);
        wr_reg(A_RFLG, 8'h01);
        rchk("rflag", A_RFLG, 8'h03, 8'h00);
        // Transmit buffers, priority order, reselection and abort
        for (int n = 0; n < 3; n++) begin
            wr_reg(A_TX0 + 7'(16 * n), 8'hA0 + 8'(n));
            wr_reg(A_TX0 + 7'(16 * n) + 7'(LOCAL_PRIORITY_FIELD_OFS), pr[n]);
        end
        wr_reg(A_TFLG, 8'h07);
        rchk("tflag", A_TFLG, 8'h07, 8'h00);
        chk("tx_irq", 8'h00, {7'h00, tx_irq});
        i_eng.arbitrate();
        chk("tx_sel", 8'h05, {5'h00, tx_sel_valid, tx_sel});
        i_eng.fetch(4'h0, d);
        chk("tx byte0", 8'hA1, d);
        i_eng.finish_tx();
        rchk("tflag", A_TFLG, 8'h07, 8'h02);
        chk("tx_irq", 8'h01, {7'h00, tx_irq});
        i_eng.arbitrate();
        chk("tx_sel", 8'h04, {5'h00, tx_sel_valid, tx_sel});
        i_eng.set_bus(1'b1);
        wr_reg(A_TCTL, 8'h05);
        rchk("abort ack", A_TCTL, 8'h70, 8'h40);
        rchk("tflag", A_TFLG, 8'h07, 8'h06);
        i_eng.finish_tx();
        rchk("abort ack", A_TCTL, 8'h70, 8'h40);
        rchk("tflag", A_TFLG, 8'h07, 8'h07);
        summarize();
    end
endmodule // cmb_top_tb
